// ==== hw/trigger_test_sequencer.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "trig_seq_defines.svh"
// Function
// R1: Program holds one to four test slots with events, actions, optional fallback.
// R2: One optional block qualification clause gates which samples are evaluated.
// R3: Only the active slot is evaluated; other slots are ignored.
// R4: Start makes slot one active, same as a jump to it.
// R5: Other slots become active only by slot jump or immediate jump command.
// R6: All events of the active slot are evaluated in parallel.
// R7: Each event combines word matches, counter reach and negations.
// R8: A true event performs its associated action; with several true, the code performs only the lowest-numbered one's.
// R9: Fallback action fires when no event of the slot is true.
// R10: Self-checks run automatically after every power-up reset.
// R11: Failed checks are reported; wait for acknowledge before diagnostics.
// R12: Option checks run and report only when option hardware is present.
// R13: A jump takes effect from the next qualified sample.
module trigger_test_sequencer #(
  parameter int NUM_TESTS = `TS_MAX_TESTS
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic sample_valid,
  input wire logic [`TS_WORDS-1:0] word_match,
  input wire trig_seq_pkg::test_hdr_t [`TS_MAX_TESTS-1:0] test_cfg,
  input wire trig_seq_pkg::event_t [`TS_MAX_TESTS*`TS_EVENTS-1:0] event_cfg,
  input wire trig_seq_pkg::qual_t qual_cfg,
  input wire logic [`TS_CNT_W-1:0] cnt_preset,
  input wire logic start,
  input wire logic imm_goto,
  input wire logic [`TS_SLOT_W-1:0] imm_slot,
  input wire logic [`TS_CHECKS-1:0] check_pass,
  input wire logic expansion_present_pin,
  input wire logic timing_present_pin,
  input wire logic ack_key,
  output logic [`TS_SLOT_W-1:0] active_slot,
  output logic running,
  output logic trigger,
  output logic store,
  output logic [`TS_CHECKS+1:0] check_fail,
  output logic [1:0] option_reported,
  output logic diag_mode,
  output logic ready
);
  import trig_seq_pkg::*;

  // Width of an index into the flat event table, slot-major.
  localparam int IDX_W = $clog2(`TS_MAX_TESTS * `TS_EVENTS);

  // The slot field is only wide enough for the documented maximum, so a
  // larger program could never be addressed; an empty one could never run.
  if (NUM_TESTS < 1 || NUM_TESTS > `TS_MAX_TESTS) begin : g_bad_num_tests
    $error("NUM_TESTS must be between 1 and 4");
  end

  seq_state_t state_reg;
  logic [`TS_CHECK_CNT_W-1:0] chk_cnt_reg;
  logic [`TS_CNT_W-1:0] count_reg;
  logic exp_s1_reg, exp_s2_reg, tim_s1_reg, tim_s2_reg;
  logic ack_s1_reg, ack_s2_reg;
  logic qualified;
  logic cnt_hit;
  logic [`TS_EVENTS-1:0] ev_true;
  logic any_true;
  action_t act_sel;
  logic act_fire;
  logic check_done;
  logic any_fail;
  logic imm_ok;
  logic goto_ok;

  // Evaluate one event: every used term is ANDed; a disabled event is false.
  function automatic logic eval_event(input event_t ev, input logic [`TS_WORDS-1:0] wm,
                                      input logic hit);
    logic r;
    r = ev.enable;
    for (int i = 0; i < `TS_WORDS; i++) begin
      if (ev.word_use[i] && (wm[i] == ev.word_neg[i])) begin
        r = 1'b0;
      end
    end
    if (ev.cnt_use && (hit == ev.cnt_neg)) begin
      r = 1'b0;
    end
    return r;
  endfunction

  // Position of one event of one slot in the flat event table.
  // Kept in one place so the evaluation and the action pick can never
  // disagree about which entry belongs to the active slot.
  function automatic logic [IDX_W-1:0] ev_index(input logic [`TS_SLOT_W-1:0] s,
                                               input int e);
    return IDX_W'(int'(s) * `TS_EVENTS + e);
  endfunction

  // A slot may be entered by a jump only if it lies inside the program and is present.
  // Both the immediate jump and an event jump go through this test, so a
  // program shorter than four slots cannot be left through either path.
  function automatic logic slot_ok(input logic [`TS_SLOT_W-1:0] s,
                                   input test_hdr_t [`TS_MAX_TESTS-1:0] cfg);
    return (int'(s) < NUM_TESTS) && cfg[s].present; // R1
  endfunction

  // Option straps and the key come from outside, so two stages first.
  always_ff @(posedge core_clk) begin
    exp_s1_reg <= expansion_present_pin;
    exp_s2_reg <= exp_s1_reg;
    tim_s1_reg <= timing_present_pin;
    tim_s2_reg <= tim_s1_reg;
    ack_s1_reg <= ack_key;
    ack_s2_reg <= ack_s1_reg;
  end

  // Block qualification drops samples where no selected word matches.
  always_comb begin
    qualified = sample_valid;
    if (qual_cfg.enable && ((word_match & qual_cfg.word_use) == {`TS_WORDS{1'b0}})) begin
      qualified = 1'b0; // R2
    end
  end

  assign cnt_hit = (count_reg >= cnt_preset); // R7

  // Only the active slot's events are examined, all at once.
  always_comb begin
    ev_true = '0;
    any_true = 1'b0;
    act_sel = '0;
    act_fire = 1'b0;
    for (int e = 0; e < `TS_EVENTS; e++) begin
      ev_true[e] = eval_event(event_cfg[ev_index(active_slot, e)], word_match,
                              cnt_hit); // R3 R6 R7
    end
    // Lowest-numbered true event wins when several fire together.
    for (int e = `TS_EVENTS-1; e >= 0; e--) begin
      if (ev_true[e]) begin
        any_true = 1'b1;
        act_sel = event_cfg[ev_index(active_slot, e)].act; // R8
      end
    end
    if (!any_true && test_cfg[active_slot].else_en) begin
      act_sel = test_cfg[active_slot].else_act; // R9
    end
    act_fire = running && qualified && (any_true || test_cfg[active_slot].else_en);
  end

  // The self-check window closes when its counter reaches the check length.
  // The results are latched in that same cycle, and the report state then
  // decides between operation and diagnostics from the latched copy.
  assign check_done = (state_reg == ST_SELFCHECK) && (chk_cnt_reg == `TS_CHECK_CYCLES);
  assign any_fail = (check_fail != '0);

  // Self-check length counter; it stops once the window has closed.
  // It only runs in the self-check state, so a later reset restarts it.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      chk_cnt_reg <= '0; // R10
    end else if ((state_reg == ST_SELFCHECK) && !check_done) begin
      chk_cnt_reg <= chk_cnt_reg + 1'b1;
    end
  end

  // Failure flags are latched once at the end of the self-check window.
  // The two option flags stay clear: their checks have no failure source
  // of their own in this block, only the presence report below.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      check_fail <= '0;
    end else if (check_done) begin
      check_fail <= {2'h0, ~check_pass}; // R11
    end
  end

  // Option hardware is reported only when its strap says it is fitted.
  // The straps pass the two-stage synchroniser, so a strap that settles
  // late after power-up is still seen before the window closes.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      option_reported <= 2'h0;
    end else if (check_done) begin
      option_reported <= {tim_s2_reg, exp_s2_reg}; // R12
    end
  end

  // Ready rises only after a clean report and stays until the next reset.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      ready <= 1'b0;
    end else if ((state_reg == ST_REPORT) && !any_fail) begin
      ready <= 1'b1; // R10
    end
  end

  // Diagnostics start only after the operator acknowledges a failure.
  // Without the key the report simply holds, so the failed checks stay
  // visible for as long as the operator needs to note them.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      diag_mode <= 1'b0;
    end else if ((state_reg == ST_REPORT) && any_fail && ack_s2_reg) begin
      diag_mode <= 1'b1; // R11
    end
  end

  // Power-up sequencing: checks, report, then operation, or on a failure acknowledge, then diagnostics.
  // Codes five to seven cannot be reached; the default returns them to
  // the self-check so an upset state never skips the checks.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      state_reg <= ST_SELFCHECK; // R10
    end else begin
      unique case (state_reg)
        ST_SELFCHECK: begin
          if (check_done) begin
            state_reg <= ST_REPORT;
          end
        end
        ST_REPORT: begin
          if (!any_fail) begin
            state_reg <= ST_IDLE;
          end else if (ack_s2_reg) begin
            state_reg <= ST_DIAG; // R11
          end
        end
        ST_IDLE: begin
          if (start) begin
            state_reg <= ST_RUN;
          end
        end
        ST_RUN: begin
          state_reg <= ST_RUN;
        end
        ST_DIAG: begin
          state_reg <= ST_DIAG;
        end
        default: begin
          state_reg <= ST_SELFCHECK;
        end
      endcase
    end
  end

  // Jump requests are screened against the program before they are taken.
  // An immediate jump outranks an event jump raised in the same cycle.
  assign imm_ok = running && imm_goto && slot_ok(imm_slot, test_cfg);
  assign goto_ok = act_fire && act_sel.do_goto && slot_ok(act_sel.goto_slot, test_cfg);

  // Active slot: start selects slot one, jumps move at the sample edge.
  // The new slot is registered, so its events are first evaluated on the
  // following qualified sample and never on the one that caused the jump.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      active_slot <= `TS_FIRST_SLOT;
      running <= 1'b0;
    end else if (ready && start) begin
      active_slot <= `TS_FIRST_SLOT; // R4
      running <= 1'b1;
    end else if (imm_ok) begin
      active_slot <= imm_slot; // R5
    end else if (goto_ok) begin
      active_slot <= act_sel.goto_slot; // R5 R13
    end
  end

  // Occurrence counter shared by the slots; reset wins over count.
  // It saturates rather than wraps, so a long run cannot make a reached
  // preset look unreached again.
  always_ff @(posedge core_clk) begin
    if (reset || (ready && start)) begin
      count_reg <= '0;
    end else if (act_fire && act_sel.do_reset_count) begin
      count_reg <= '0;
    end else if (act_fire && act_sel.do_count && count_reg != {`TS_CNT_W{1'b1}}) begin
      count_reg <= count_reg + 1'b1;
    end
  end

  // Action outputs are one-cycle pulses per qualified sample.
  // They are registered so downstream capture sees clean edges; the cost
  // is one cycle of latency after the sample that fired them.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      trigger <= 1'b0;
      store <= 1'b0;
    end else begin
      trigger <= act_fire && act_sel.do_trigger; // R8
      store <= act_fire && act_sel.do_store;
    end
  end
endmodule
`default_nettype wire

// ==== hw/trig_seq_defines.svh ====
`ifndef TRIG_SEQ_DEFINES_SVH
`define TRIG_SEQ_DEFINES_SVH
`define TS_MAX_TESTS 4
`define TS_EVENTS 4
`define TS_WORDS 4
`define TS_CHECKS 4
`define TS_SLOT_W 2
`define TS_FIRST_SLOT 2'h0
`define TS_CNT_W 16
`define TS_CHECK_CYCLES 8'h10
`define TS_CHECK_CNT_W 8
`endif

// ==== hw/trig_seq_pkg.sv ====
`include "trig_seq_defines.svh"
package trig_seq_pkg;
  // Action taken when an event or the fallback fires.
  typedef struct packed {
    logic do_goto;
    logic [`TS_SLOT_W-1:0] goto_slot;
    logic do_trigger;
    logic do_count;
    logic do_reset_count;
    logic do_store;
  } action_t;

  // One event: word and counter term masks with negations.
  typedef struct packed {
    logic enable;
    logic [`TS_WORDS-1:0] word_use;
    logic [`TS_WORDS-1:0] word_neg;
    logic cnt_use;
    logic cnt_neg;
    action_t act;
  } event_t;

  typedef struct packed {
    logic present;
    logic else_en;
    action_t else_act;
  } test_hdr_t;

  // Block qualification clause.
  typedef struct packed {
    logic enable;
    logic [`TS_WORDS-1:0] word_use;
  } qual_t;

  typedef enum logic [2:0] {
    ST_SELFCHECK = 3'h0,
    ST_REPORT = 3'h1,
    ST_IDLE = 3'h2,
    ST_RUN = 3'h3,
    ST_DIAG = 3'h4
  } seq_state_t;
endpackage

// ==== testbench/trig_seq_props.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "trig_seq_defines.svh"
// Ties each sequencer output except option_reported to its cause at the inputs.
module trig_seq_props (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic sample_valid,
  input wire logic start,
  input wire logic [`TS_SLOT_W-1:0] active_slot,
  input wire logic running,
  input wire logic trigger,
  input wire logic store,
  input wire logic [`TS_CHECKS+1:0] check_fail,
  input wire logic diag_mode,
  input wire logic ready
);
  logic [4:0] up_cnt;
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  // Saturating age since reset, so a ready that skips the self-check shows up.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      up_cnt <= 5'h00;
    end else if (up_cnt != 5'h1F) begin
      up_cnt <= up_cnt + 5'h01;
    end
  end
  a_ready_early: assert property (up_cnt < 5'h10 |-> !ready)
    else $error("ready before self-check done");
  a_ready_clean: assert property (ready |-> check_fail == 6'h00)
    else $error("ready with a failed check");
  a_diag_sticky: assert property (diag_mode |=> diag_mode)
    else $error("diagnostic mode dropped");
  a_diag_cause: assert property ($rose(diag_mode) |-> check_fail != 6'h00)
    else $error("diagnostic mode without failure");
  a_start_slot: assert property (ready && start |=> running && active_slot == 2'h0)
    else $error("start did not select first slot");
  a_start_early: assert property (start && !ready && !running |=> !running)
    else $error("start taken before ready");
  a_trig_sample: assert property (trigger |-> $past(sample_valid) && $past(running))
    else $error("trigger without a sample");
  a_store_sample: assert property (store |-> $past(sample_valid) && $past(running))
    else $error("store without a sample");
  a_slot_cause: assert property ($changed(active_slot) |-> $past(start) || $past(running))
    else $error("slot moved while idle");
  a_opt_clear: assert property (check_fail[5:4] == 2'h0)
    else $error("option failure flagged");
endmodule
bind trigger_test_sequencer trig_seq_props u_props (.core_clk, .reset, .sample_valid, .start,
  .active_slot, .running, .trigger, .store, .check_fail, .diag_mode, .ready);
`default_nettype wire

// ==== testbench/bus_side_model.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "trig_seq_defines.svh"
// Probe side: one valid sample per go cycle; idle cycles show the inverse word.
module bus_side_model (
  input wire logic go,
  input wire logic [`TS_WORDS-1:0] want,
  output logic sample_valid,
  output logic [`TS_WORDS-1:0] word_match
);
  assign sample_valid = go;
  assign word_match = go ? want : ~want;
endmodule
`default_nettype wire

// ==== testbench/trigger_test_sequencer_tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) num_checks++; if ((a) !== (b)) begin n_mismatch++; \
  $display("[ERR] t=%0t got=%h exp=%h", $time, a, b); end
module trigger_test_sequencer_tb_top;
  import trig_seq_pkg::*;
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic start = 1'b0;
  logic imm_goto = 1'b0;
  logic [1:0] imm_slot = 2'h0;
  logic [3:0] check_pass = 4'hF;
  logic ack_key = 1'b0;
  logic go = 1'b0;
  logic [3:0] want = 4'h0;
  logic sample_valid, running, trigger, store, diag_mode, ready;
  logic [3:0] word_match, w;
  logic [1:0] active_slot, option_reported;
  logic [5:0] check_fail;
  test_hdr_t [3:0] tc = '0;
  event_t [15:0] ec = '0;
  qual_t qc = '0;
  int n_mismatch = 0;
  int num_checks = 0;
  int k;
  initial forever #2 core_clk = ~core_clk;
  bus_side_model u_bus (.go, .want, .sample_valid, .word_match);
  trigger_test_sequencer u_dut (.core_clk, .reset, .sample_valid, .word_match, .test_cfg(tc),
    .event_cfg(ec), .qual_cfg(qc), .cnt_preset(16'h0004), .start, .imm_goto,
    .imm_slot, .check_pass, .expansion_present_pin(1'b1), .timing_present_pin(1'b0),
    .ack_key, .active_slot, .running, .trigger, .store, .check_fail, .option_reported,
    .diag_mode, .ready);
  // Slot four stores on word two, otherwise its fallback triggers.
  function automatic logic [1:0] exp_ts(input logic [3:0] v);
    return v[2] ? 2'h1 : 2'h2;
  endfunction
  task automatic pulse_cmd(input logic s, input logic g, input logic [1:0] sl);
    @(posedge core_clk);
    start <= s;
    imm_goto <= g;
    imm_slot <= sl;
    @(posedge core_clk);
    start <= 1'b0;
    imm_goto <= 1'b0;
    #1;
  endtask
  task automatic smp(input logic [3:0] v);
    @(posedge core_clk);
    go <= 1'b1;
    want <= v;
    @(posedge core_clk);
    go <= 1'b0;
    #1;
  endtask
  task automatic close_out();
    $display("checks=%0d mismatches=%0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // Program: slot one jumps on word zero, slot two stores on word one.
  initial begin
    void'($urandom(55636));
    for (k = 0; k < 4; k++) tc[k].present = 1'b1;
    tc[3].else_en = 1'b1;
    tc[3].else_act.do_trigger = 1'b1;
    ec[0].enable = 1'b1;
    ec[0].word_use = 4'h1;
    ec[0].act = '{1'b1, 2'h1, 1'b1, 1'b0, 1'b0, 1'b0};
    ec[4].enable = 1'b1;
    ec[4].word_use = 4'h2;
    ec[4].act.do_store = 1'b1;
    ec[12].enable = 1'b1;
    ec[12].word_use = 4'h4;
    ec[12].act.do_store = 1'b1;
    repeat (2) @(posedge core_clk);
    reset <= 1'b0;
    pulse_cmd(1'b1, 1'b0, 2'h0);
    `CHK(running, 1'b0)
    for (k = 0; k < 40 && ready !== 1'b1; k++) @(posedge core_clk);
    #1;
    `CHK({ready, check_fail}, 7'h40)
    `CHK(option_reported, 2'h1)
    if (ready !== 1'b1) close_out();
    pulse_cmd(1'b1, 1'b0, 2'h0);
    `CHK({running, active_slot}, 3'h4)
    smp(4'h2);
    `CHK({trigger, store, active_slot}, 4'h0)
    smp(4'h1);
    `CHK({trigger, active_slot}, 3'h5)
    smp(4'h2);
    `CHK({store, active_slot}, 3'h5)
    pulse_cmd(1'b0, 1'b1, 2'h3);
    `CHK(active_slot, 2'h3)
    // Random words keep the store event and the fallback racing each other.
    for (int n = 0; n < 24; n++) begin
      w = 4'($urandom);
      smp(w);
      `CHK({trigger, store}, exp_ts(w))
    end
    // Qualification on word three: a sample without it does nothing.
    qc <= '{1'b1, 4'h8};
    smp(4'h4);
    `CHK({trigger, store}, 2'h0)
    smp(4'hC);
    `CHK({trigger, store}, 2'h1)
    @(posedge core_clk);
    check_pass <= 4'hE;
    reset <= 1'b1;
    repeat (2) @(posedge core_clk);
    reset <= 1'b0;
    repeat (40) @(posedge core_clk);
    #1;
    `CHK({ready, diag_mode, check_fail}, 8'h01)
    @(posedge core_clk);
    ack_key <= 1'b1;
    for (k = 0; k < 10 && diag_mode !== 1'b1; k++) @(posedge core_clk);
    #1;
    `CHK(diag_mode, 1'b1)
    close_out();
  end
endmodule
`default_nettype wire
